// ==== core/volt_regs.v ====
// Purpose: Charge voltage limit and system floor voltage register bank
// Assumes: Host uses the two-wire serial port, strap is stable after reset
// Notes:   A 16-bit word commits when its high byte arrives
//          A charge high byte sent alone commits with the last charge low byte
//          Dropped words are still acknowledged; nothing flags them
//          Pointer steps by one after every data byte, read or written
//
// Contract
// R1: Floor voltage six bits, 256 mV steps
// R2: Floor accepts 1.024 V to 16.128 V
// R3: Out-of-range floor writes keep old value
// R4: Floor default from cell count strap
// R5: Charge limit eleven bits, 16 mV steps
// R6: Ones in reserved top bits invalidate write
// R7: Charge low nibble ignored, reads zero
// R8: Host writes floor as one 16-bit word
// R9: Charge accepts 1.024 V to 19.200 V
// R10: Charge default from cell count strap
// R11: Zero charge write restores default, stops charging
// R12: Reads return stored fields, reserved zero
`timescale 1ns/100ps
`include "volt_regs_defines.vh"
module volt_regs #(
  parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // Arbitrary value
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Serial pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Strap
  input wire [1:0] cell_count_strap,
  // Set points to the regulation loops
  output reg [10:0] charge_voltage_limit,
  output reg [5:0] system_floor_voltage,
  output reg charge_current_clear
);

  // ==========================================================
  // Declarations
  // ==========================================================
  wire start_pulse; // Start seen on the bus
  wire rx_valid; // Written byte pulse
  wire [7:0] rx_data; // Written byte
  wire rd_done; // Read byte finished
  reg [7:0] rd_data_reg; // Byte offered to a read
  reg [7:0] ptr_reg; // Register pointer
  reg ptr_loaded_reg; // Pointer byte already taken
  reg [7:0] chg_low_hold_reg; // Pending charge low byte
  reg init_done_reg; // Strap defaults loaded
  reg [10:0] chg_default; // Strap default for charge
  reg [5:0] sys_default; // Strap default for floor
  reg [10:0] chg_code; // Candidate charge code
  reg [5:0] sys_code; // Candidate floor code
  reg chg_rsvd_bad; // Charge high byte reserved bit set
  reg sys_rsvd_bad; // Floor high byte reserved bits set
  reg chg_is_zero; // Charge word asks for the default
  reg chg_in_range; // Charge code inside the legal span
  reg sys_in_range; // Floor code inside the legal span

  // ==========================================================
  // Serial byte engine
  // ==========================================================
  serial_byte_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .start_pulse(start_pulse),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rd_done(rd_done),
    .tx_data(rd_data_reg)
  );

  // ==========================================================
  // Strap decode
  // ==========================================================
  // Defaults per cell count
  always @* begin
    case (cell_count_strap)
      2'd0: begin
        // One cell
        chg_default = `CHG_DEF_1CELL; // R10
        sys_default = `SYS_DEF_1CELL; // R4
      end
      2'd1: begin
        // Two cells
        chg_default = `CHG_DEF_2CELL;
        sys_default = `SYS_DEF_2CELL;
      end
      2'd2: begin
        // Three cells
        chg_default = `CHG_DEF_3CELL;
        sys_default = `SYS_DEF_3CELL;
      end
      default: begin
        // Four cells
        chg_default = `CHG_DEF_4CELL;
        sys_default = `SYS_DEF_4CELL;
      end
    endcase
  end

  // ==========================================================
  // Candidate codes from the incoming word
  // ==========================================================
  // Eleven-bit charge field and six-bit floor field
  always @* begin
    chg_code = {rx_data[6:0], chg_low_hold_reg[7:`CHG_LOW_FIELD_LSB]}; // R5 R7
    sys_code = rx_data[5:0]; // R1
  end

  // ==========================================================
  // Write qualification
  // ==========================================================
  // Checks on the high byte and the word it completes
  always @* begin
    // Any one in a reserved top bit spoils the whole word
    chg_rsvd_bad = rx_data[`CHG_HIGH_RSVD_BIT]; // R6
    sys_rsvd_bad = (rx_data[`SYS_HIGH_RSVD_MSB:`SYS_HIGH_RSVD_LSB] != 2'b00); // R6
    // Zero asks for the strap default, it is no set point
    chg_is_zero = (chg_code == 11'h000); // R11
    chg_in_range = (chg_code >= `CHG_MIN_CODE) && (chg_code <= `CHG_MAX_CODE); // R9
    sys_in_range = (sys_code >= `SYS_MIN_CODE) && (sys_code <= `SYS_MAX_CODE); // R2 R3
  end

  // ==========================================================
  // Pointer and write handling
  // ==========================================================
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_reg <= 8'h00;
      ptr_loaded_reg <= 1'b0;
      chg_low_hold_reg <= 8'h00;
      init_done_reg <= 1'b0;
      charge_voltage_limit <= 11'h000;
      system_floor_voltage <= 6'h00;
      charge_current_clear <= 1'b0;
    end else begin
      charge_current_clear <= 1'b0;
      if (!init_done_reg) begin
        // Strap caught on the first edge after release
        init_done_reg <= 1'b1;
        charge_voltage_limit <= chg_default; // R10
        system_floor_voltage <= sys_default; // R4
      end
      if (start_pulse) begin
        // New transfer expects a pointer byte
        ptr_loaded_reg <= 1'b0;
      end else if (rx_valid && !ptr_loaded_reg) begin
        // First written byte sets the pointer
        ptr_reg <= rx_data;
        ptr_loaded_reg <= 1'b1;
      end else if (rx_valid) begin
        // Data byte at the pointer, pointer steps on
        ptr_reg <= ptr_reg + 8'h01;
        if (ptr_reg == `ADDR_CHG_LIMIT_LOW) begin
          // Charge low byte waits for its high byte
          chg_low_hold_reg <= rx_data;
        end else if (ptr_reg == `ADDR_SYS_FLOOR_LOW) begin
          // Low byte of the floor word carries nothing
        end else if (ptr_reg == `ADDR_CHG_LIMIT_HIGH) begin
          // High byte completes the charge word
          if (chg_rsvd_bad) begin
            // Invalid write dropped
            charge_voltage_limit <= charge_voltage_limit; // R6
          end else if (chg_is_zero) begin
            // Default back, charge current forced off
            charge_voltage_limit <= chg_default; // R11
            charge_current_clear <= 1'b1; // R11
          end else if (chg_in_range) begin
            // Accepted set point
            charge_voltage_limit <= chg_code; // R9
          end
          // Codes out of range keep the old value
        end else if (ptr_reg == `ADDR_SYS_FLOOR_HIGH) begin
          // High byte completes the floor word
          if (sys_rsvd_bad) begin
            // Invalid write dropped
            system_floor_voltage <= system_floor_voltage; // R6
          end else if (sys_in_range) begin
            // Accepted set point
            system_floor_voltage <= sys_code; // R2 R3
          end
          // Codes below the minimum keep the old value
        end else begin
          // Other addresses are acked and ignored
        end
      end else if (rd_done) begin
        // Reads walk the pointer too
        ptr_reg <= ptr_reg + 8'h01;
      end
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  // Byte at the pointer, reserved bits zero
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg <= 8'h00;
    end else if (ptr_reg == `ADDR_CHG_LIMIT_LOW) begin
      // Low four charge bits, ignored nibble zero
      rd_data_reg <= {charge_voltage_limit[3:0], 4'h0}; // R12 R7
    end else if (ptr_reg == `ADDR_CHG_LIMIT_HIGH) begin
      // Upper seven charge bits, reserved bit zero
      rd_data_reg <= {1'b0, charge_voltage_limit[10:4]}; // R12
    end else if (ptr_reg == `ADDR_SYS_FLOOR_HIGH) begin
      // Floor code, reserved pair zero
      rd_data_reg <= {2'b00, system_floor_voltage}; // R12
    end else begin
      // Floor low byte and unknown addresses read zero
      rd_data_reg <= 8'h00;
    end
  end

endmodule // volt_regs

// ==== core/volt_regs_defines.vh ====
// Purpose: Constants for the charge voltage and system floor voltage registers
// Assumes: Byte-wide register addresses reached through the two-wire serial port
// Notes:   Field codes are in units of one step (16 mV or 256 mV)
`ifndef VOLT_REGS_DEFINES_VH
`define VOLT_REGS_DEFINES_VH

// ==========================================================
// Register addresses
// ==========================================================
`define ADDR_CHG_LIMIT_LOW 8'h04
`define ADDR_CHG_LIMIT_HIGH 8'h05
`define ADDR_SYS_FLOOR_LOW 8'h0C
`define ADDR_SYS_FLOOR_HIGH 8'h0D

// ==========================================================
// Field layout
// ==========================================================
`define CHG_HIGH_RSVD_BIT 7
`define CHG_LOW_FIELD_LSB 4
`define SYS_HIGH_RSVD_MSB 7
`define SYS_HIGH_RSVD_LSB 6

// ==========================================================
// Step sizes in mV
// ==========================================================
`define CHG_STEP_MV 16
`define SYS_STEP_MV 256

// ==========================================================
// Accepted ranges as field codes
// ==========================================================
`define CHG_MIN_CODE 11'h040
`define CHG_MAX_CODE 11'h4B0
`define SYS_MIN_CODE 6'h04
`define SYS_MAX_CODE 6'h3F

// ==========================================================
// Strap-chosen defaults as field codes
// ==========================================================
`define CHG_DEF_1CELL 11'h106
`define CHG_DEF_2CELL 11'h20D
`define CHG_DEF_3CELL 11'h313
`define CHG_DEF_4CELL 11'h41A
`define SYS_DEF_1CELL 6'h0E
`define SYS_DEF_2CELL 6'h18
`define SYS_DEF_3CELL 6'h24
`define SYS_DEF_4CELL 6'h30

// ==========================================================
// Serial port
// ==========================================================
`define DEV_ADDR_DEFAULT 7'h55

`endif

// ==== core/serial_byte_slave.v ====
// Purpose: Two-wire serial slave that turns bus traffic into byte events
// Assumes: scl and sda inputs are synchronous to clk and far slower than it
// Notes:   Acks its own address and every written byte; sda is open drain
`timescale 1ns/100ps
module serial_byte_slave #(
  parameter [6:0] DEV_ADDR = 7'h55
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Serial pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Byte events
  output reg start_pulse,
  output reg rx_valid,
  output reg [7:0] rx_data,
  output reg rd_done,
  input wire [7:0] tx_data
);

  // States of the byte engine
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_WR = 3'd2;
  localparam [2:0] S_RD = 3'd3;
  localparam [2:0] S_MACK = 3'd4;

  reg scl_q; // Previous scl
  reg sda_q; // Previous sda
  reg [2:0] st_reg; // Engine state
  reg [2:0] cnt_reg; // Bit counter
  reg [7:0] sh_reg; // Shift register
  reg rw_reg; // Read when set
  reg ack_pend_reg; // Ack due at next fall
  reg in_ack_reg; // Ack bit on the wire
  reg oe_reg; // Pulls sda low

  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;
  wire [7:0] byte_in = {sh_reg[6:0], sda_in};

  // Open drain: only ever drives low
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;

  // ==========================================================
  // Byte engine
  // ==========================================================
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_reg <= S_IDLE;
      cnt_reg <= 3'd0;
      sh_reg <= 8'h00;
      rw_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      in_ack_reg <= 1'b0;
      oe_reg <= 1'b0;
      start_pulse <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rd_done <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      start_pulse <= 1'b0;
      rx_valid <= 1'b0;
      rd_done <= 1'b0;
      if (start_cond) begin
        // Start or repeated start
        st_reg <= S_ADDR;
        cnt_reg <= 3'd0;
        ack_pend_reg <= 1'b0;
        in_ack_reg <= 1'b0;
        oe_reg <= 1'b0;
        start_pulse <= 1'b1;
      end else if (stop_cond) begin
        // Stop releases the bus
        st_reg <= S_IDLE;
        ack_pend_reg <= 1'b0;
        in_ack_reg <= 1'b0;
        oe_reg <= 1'b0;
      end else if (scl_rise && !in_ack_reg) begin
        case (st_reg)
          S_ADDR, S_WR: begin
            // Sample one bit
            sh_reg <= byte_in;
            cnt_reg <= cnt_reg + 3'd1;
            if (cnt_reg == 3'd7) begin
              if (st_reg == S_WR) begin
                rx_valid <= 1'b1;
                rx_data <= byte_in;
                ack_pend_reg <= 1'b1;
              end else if (byte_in[7:1] == DEV_ADDR) begin
                rw_reg <= byte_in[0];
                ack_pend_reg <= 1'b1;
              end else begin
                st_reg <= S_IDLE;
              end
            end
          end
          S_RD: begin
            // Shift out the next bit
            sh_reg <= {sh_reg[6:0], 1'b0};
            cnt_reg <= cnt_reg + 3'd1;
            if (cnt_reg == 3'd7) begin
              st_reg <= S_MACK;
              rd_done <= 1'b1;
            end
          end
          S_MACK: begin
            // Master ack continues the read
            if (!sda_in) begin
              st_reg <= S_RD;
              sh_reg <= tx_data;
            end else begin
              st_reg <= S_IDLE;
            end
          end
          default: begin
            st_reg <= S_IDLE;
          end
        endcase
      end else if (scl_fall) begin
        if (ack_pend_reg) begin
          // Pull the ack bit
          oe_reg <= 1'b1;
          ack_pend_reg <= 1'b0;
          in_ack_reg <= 1'b1;
        end else if (in_ack_reg) begin
          // Ack bit finished
          in_ack_reg <= 1'b0;
          if (st_reg == S_ADDR && rw_reg) begin
            st_reg <= S_RD;
            sh_reg <= tx_data;
            oe_reg <= ~tx_data[7];
          end else begin
            st_reg <= S_WR;
            oe_reg <= 1'b0;
          end
        end else if (st_reg == S_RD) begin
          oe_reg <= ~sh_reg[7];
        end else begin
          oe_reg <= 1'b0;
        end
      end
    end
  end

endmodule // serial_byte_slave

// ==== verif/volt_regs_sva.sv ====
// Purpose: Port-level checks of the voltage set point register bank
// Assumes: One clock, reset asynchronous and active high
// Notes:   Bound onto every volt_regs instance
`timescale 1ns/100ps
module volt_regs_sva (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Serial pins
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  // Strap and set points
  input wire [1:0] cell_count_strap,
  input wire [10:0] charge_voltage_limit,
  input wire [5:0] system_floor_voltage,
  input wire charge_current_clear
);
  // ==========================================
  // Strap defaults as codes
  // ==========================================
  wire [10:0] chg_def = cell_count_strap == 2'h0 ? 11'h106 :
    cell_count_strap == 2'h1 ? 11'h20D : cell_count_strap == 2'h2 ? 11'h313 : 11'h41A;
  wire [5:0] flr_def = cell_count_strap == 2'h0 ? 6'h0E :
    cell_count_strap == 2'h1 ? 6'h18 : cell_count_strap == 2'h2 ? 6'h24 : 6'h30;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Assertions
  // ==========================================
  drain_only_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  strap_default_a: assert property ($fell(sys_rst) |=>
    charge_voltage_limit == chg_def && system_floor_voltage == flr_def)
    else $error("set points not at strap defaults");
  chg_range_a: assert property (!$past(sys_rst) |->
    charge_voltage_limit inside {[11'h040:11'h4B0]})
    else $error("charge limit out of range");
  floor_range_a: assert property (!$past(sys_rst) |-> system_floor_voltage >= 6'h04)
    else $error("floor below range");
  clear_restores_a: assert property (charge_current_clear |->
    ##[0:1] charge_voltage_limit == chg_def)
    else $error("zero write did not restore default");
  clear_single_a: assert property (charge_current_clear |=> !charge_current_clear)
    else $error("clear pulse too long");
  chg_commit_a: assert property ($changed(charge_voltage_limit) && !$past(sys_rst, 2)
    |-> $past(scl_in))
    else $error("charge limit moved outside a byte");
  floor_commit_a: assert property ($changed(system_floor_voltage) && !$past(sys_rst, 2)
    |-> $past(scl_in))
    else $error("floor moved outside a byte");
  ack_rise_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled while clock high");
  ack_fall_a: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released while clock high");
endmodule // volt_regs_sva
bind volt_regs volt_regs_sva i_volt_regs_sva (.clk(clk), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .cell_count_strap(cell_count_strap), .charge_voltage_limit(charge_voltage_limit),
  .system_floor_voltage(system_floor_voltage), .charge_current_clear(charge_current_clear));

// ==== verif/serial_host_model.sv ====
// Purpose: Two-wire host that writes words and reads bytes
// Assumes: Wire is pulled up; phases of five clocks
// Notes:   Address may be changed by the bench to miss the device
`timescale 1ns/100ps
module serial_host_model #(
  parameter [6:0] DEV = 7'h55
) (
  // Clock
  input wire clk,
  // Serial wire
  output reg scl,
  output reg sda_pull,
  input wire sda
);
  reg [6:0] dev = DEV; // Target address
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task w5;
    repeat (5) @(posedge clk);
  endtask
  // One bit out, wire sampled while clock high
  task bit_io(input b, output r);
    begin
      sda_pull <= !b;
      w5;
      scl <= 1'b1;
      w5;
      r = sda;
      scl <= 1'b0;
      w5;
    end
  endtask
  // Start or repeated start
  task start_c;
    begin
      sda_pull <= 1'b0;
      w5;
      scl <= 1'b1;
      w5;
      sda_pull <= 1'b1;
      w5;
      scl <= 1'b0;
      w5;
    end
  endtask
  task stop_c;
    begin
      sda_pull <= 1'b1;
      w5;
      scl <= 1'b1;
      w5;
      sda_pull <= 1'b0;
      w5;
    end
  endtask
  // Eight bits then acknowledge slot
  task byte_io(input [7:0] b, input rel, output [7:0] q, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(b[i], r);
        q[i] = r;
      end
      bit_io(rel, r);
      ack = !r;
    end
  endtask
  // Pointer, low byte, high byte in one frame
  task wr_word(input [7:0] p, input [15:0] w, output ok);
    reg [7:0] q;
    reg a0, a1, a2, a3;
    begin
      start_c;
      byte_io({dev, 1'b0}, 1'b1, q, a0);
      byte_io(p, 1'b1, q, a1);
      byte_io(w[7:0], 1'b1, q, a2);
      byte_io(w[15:8], 1'b1, q, a3);
      stop_c;
      ok = a0 & a1 & a2 & a3;
    end
  endtask
  task rd_byte(input [7:0] p, output [7:0] d);
    reg [7:0] q;
    reg a;
    begin
      start_c;
      byte_io({dev, 1'b0}, 1'b1, q, a);
      byte_io(p, 1'b1, q, a);
      start_c;
      byte_io({dev, 1'b1}, 1'b1, q, a);
      byte_io(8'hFF, 1'b1, d, a);
      stop_c;
    end
  endtask
  // Two bytes in one read, host acks the first
  task rd_two(input [7:0] p, output [7:0] d0, output [7:0] d1);
    reg [7:0] q;
    reg a;
    begin
      start_c;
      byte_io({dev, 1'b0}, 1'b1, q, a);
      byte_io(p, 1'b1, q, a);
      start_c;
      byte_io({dev, 1'b1}, 1'b1, q, a);
      byte_io(8'hFF, 1'b0, d0, a);
      byte_io(8'hFF, 1'b1, d1, a);
      stop_c;
    end
  endtask
endmodule // serial_host_model

// ==== verif/test_volt_regs.sv ====
// Purpose: Self-checking bench for the voltage set point registers
// Assumes: Host model on the serial wire
// Notes:   Codes are in 16 mV and 256 mV steps
`timescale 1ns/100ps
`include "volt_regs_defines.vh"
`define CHK(a, b) begin \
  comparisons = comparisons + 1; \
  if ((a) !== (b)) begin \
    num_errors = num_errors + 1; \
    $display("mismatch at %0t: got %h exp %h", $time, a, b); \
  end \
end
module test_volt_regs;
  localparam [6:0] DEV = 7'h55; // Arbitrary value
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [1:0] cell_count_strap = 2'h0;
  wire scl, sda_pull, sda_out, sda_oe, chg_clr;
  wire [10:0] chg;
  wire [5:0] flr;
  wire sda = !(sda_pull | sda_oe); // Pulled-up wire
  integer num_errors = 0;
  integer comparisons = 0;
  integer n_clr = 0;
  reg ok;
  reg [7:0] d;
  reg [7:0] d2;
  reg [10:0] cdef [0:3] = '{11'h106, 11'h20D, 11'h313, 11'h41A};
  reg [5:0] fdef [0:3] = '{6'h0E, 6'h18, 6'h24, 6'h30};
  always #2 clk = !clk;
  always @(posedge clk) if (chg_clr === 1'b1) n_clr <= n_clr + 1;
  volt_regs #(.DEV_ADDR(DEV)) i_volt_regs (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .cell_count_strap(cell_count_strap),
    .charge_voltage_limit(chg), .system_floor_voltage(flr), .charge_current_clear(chg_clr));
  serial_host_model #(.DEV(DEV)) i_serial_host_model (.clk(clk), .scl(scl),
    .sda_pull(sda_pull), .sda(sda));
  task host_wr(input [7:0] p, input [15:0] w);
    begin
      i_serial_host_model.wr_word(p, w, ok);
      `CHK(ok, 1'b1)
    end
  endtask
  task host_rd(input [7:0] p, input [7:0] e);
    begin
      i_serial_host_model.rd_byte(p, d);
      `CHK(d, e)
    end
  endtask
  task wc(input [10:0] v, input [7:0] x, input [10:0] e);
    begin
      host_wr(`ADDR_CHG_LIMIT_LOW, {x | {1'b0, v[10:4]}, v[3:0], 4'hA});
      `CHK(chg, e)
    end
  endtask
  task wf(input [5:0] v, input [7:0] x, input [5:0] e);
    begin
      host_wr(`ADDR_SYS_FLOOR_LOW, {x | {2'b00, v}, 8'hA5});
      `CHK(flr, e)
    end
  endtask
  task t_defaults;
    integer s;
    begin
      for (s = 0; s < 4; s = s + 1) begin
        cell_count_strap <= s[1:0];
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(chg, cdef[s])
        `CHK(flr, fdef[s])
      end
      $display("strap default test done");
    end
  endtask
  task t_charge;
    begin
      wc(11'h4B0, 8'h00, 11'h4B0);
      wc(11'h4B1, 8'h00, 11'h4B0);
      wc(11'h040, 8'h00, 11'h040);
      wc(11'h03F, 8'h00, 11'h040);
      wc(11'h107, 8'h80, 11'h040);
      wc(11'h107, 8'h00, 11'h107);
      host_rd(`ADDR_CHG_LIMIT_LOW, 8'h70);
      host_rd(`ADDR_CHG_LIMIT_HIGH, 8'h10);
      i_serial_host_model.rd_two(`ADDR_CHG_LIMIT_LOW, d, d2);
      `CHK(d, 8'h70)
      `CHK(d2, 8'h10)
      $display("charge limit test done");
    end
  endtask
  task t_floor;
    begin
      wf(6'h3F, 8'h00, 6'h3F);
      wf(6'h04, 8'h00, 6'h04);
      wf(6'h03, 8'h00, 6'h04);
      wf(6'h21, 8'h00, 6'h21);
      wf(6'h05, 8'h80, 6'h21);
      wf(6'h05, 8'h40, 6'h21);
      host_rd(`ADDR_SYS_FLOOR_HIGH, 8'h21);
      host_rd(`ADDR_SYS_FLOOR_LOW, 8'h00);
      $display("floor test done");
    end
  endtask
  task t_zero;
    integer n0;
    begin
      n0 = n_clr;
      host_wr(`ADDR_CHG_LIMIT_LOW, 16'h0000);
      `CHK(n_clr, n0 + 1)
      `CHK(chg, cdef[3])
      $display("zero write test done");
    end
  endtask
  task t_addr;
    begin
      i_serial_host_model.dev = ~DEV;
      i_serial_host_model.wr_word(`ADDR_CHG_LIMIT_LOW, 16'h1070, ok);
      `CHK(ok, 1'b0)
      `CHK(chg, cdef[3])
      i_serial_host_model.dev = DEV;
      $display("foreign address test done");
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #200000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial begin
    @(posedge clk);
    t_defaults;
    t_charge;
    t_floor;
    t_zero;
    t_addr;
    wrap_up;
  end
endmodule // test_volt_regs
